// File: omb_pkg.sv
// Shared constants and types of the output mapping broker
package omb_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_CONS  = 3;
  localparam int NUM_AREAS = 4;
  localparam int IN_WORDS  = 64;
  localparam int OUT_WORDS = 16;

  // ----------------------------------------
  // Input region, area limits and timeout reset value
  // ----------------------------------------
  localparam logic [15:0] IN_BASE  = 16'h0100;
  localparam logic [7:0]  CNT_MAX  = 8'h10;
  localparam logic [7:0]  TMO_RST  = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MS_NS      = 1000000;
  localparam int CLK_NS     = 100;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {DEF_HOLD, DEF_ZEROS, DEF_ONES} omb_def_type;
  localparam omb_def_type DEF_RST = DEF_HOLD;

  typedef struct packed {
    logic [15:0] start;
    logic [7:0]  count;
  } omb_area_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } omb_wr_type;

  typedef struct packed {
    logic [1:0]   cons;
    logic [1:0]   area;
    omb_area_type ent;
  } omb_cfg_type;

endpackage

// File: omb_broker.sv
// Output mapping broker: area routing, validity timeout, default data
//
// What this block does
// RQ1 - Up to four start/count areas per consumer
// RQ2 - Separate mapping, timeout, default per consumer
// RQ3 - Areas only from the input region
// RQ4 - Reject bad start or count with error
// RQ5 - New mapping used only after restart
// RQ6 - Optional timeout substitutes default on invalid data
// RQ7 - Default: all ones, all zeros, or hold
// RQ8 - Timeout 0 to 255 ms, eight bits
// RQ9 - Zero timeout disables substitution
// RQ10 - Stale source past timeout gives default data
// RQ11 - Fresh data restarts timer, resumes mapped data
`timescale 1ns/100ps
module omb_broker #(
  parameter int unsigned CYC_PER_MS = omb_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 nrst_i,
  // Producer writes into the input region
  input  wire logic                 prod_wr_i,
  input  wire omb_pkg::omb_wr_type  prod_i,
  // Mapping entry writes
  input  wire logic                 map_wr_i,
  input  wire omb_pkg::omb_cfg_type map_i,
  output logic                      map_ack_o,
  output logic                      map_err_o,
  // Timeout and default settings
  input  wire logic                 set_wr_i,
  input  wire logic [1:0]           set_cons_i,
  input  wire logic [7:0]           set_tmo_i,
  input  wire omb_pkg::omb_def_type set_def_i,
  // Module restart
  input  wire logic                 restart_i,
  // Consumer output read port
  input  wire logic [1:0]           rd_cons_i,
  input  wire logic [3:0]           rd_idx_i,
  output logic [15:0]               rd_data_o,
  output logic [4:0]                rd_len_o,
  output logic [2:0]                stale_o
);
  import omb_pkg::*;

  typedef enum logic {ST_LOAD, ST_RUN} omb_st_type;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0]  in_mem  [IN_WORDS];
  logic [15:0]  out_mem [NUM_CONS][OUT_WORDS];
  logic [4:0]   len_q   [NUM_CONS];
  omb_area_type pend_q  [NUM_CONS][NUM_AREAS];
  omb_area_type act_q   [NUM_CONS][NUM_AREAS];
  logic [7:0]   tmo_pend_q [NUM_CONS];
  logic [7:0]   tmo_q      [NUM_CONS];
  omb_def_type  def_pend_q [NUM_CONS];
  omb_def_type  def_q      [NUM_CONS];
  logic [7:0]   tmr_q      [NUM_CONS];
  logic [2:0]   stale_q;
  logic [2:0]   fresh;

  // ----------------------------------------
  // Entry check
  // ----------------------------------------
  wire  [16:0] ent_off  = {1'b0, map_i.ent.start} - {1'b0, IN_BASE};
  wire  [16:0] ent_end  = ent_off + {9'h000, map_i.ent.count};
  // RQ3 start inside input region
  wire         ent_in   = (map_i.ent.start >= IN_BASE) && (ent_off < 17'(IN_WORDS));
  // RQ4 count limit check
  wire         ent_ok   = ent_in && (map_i.ent.count <= CNT_MAX)
                          && (ent_end <= 17'(IN_WORDS)) && (map_i.cons != 2'h3);

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      map_ack_o <= 1'b0;
      map_err_o <= 1'b0;
    end else begin
      // RQ4 reject with error
      map_ack_o <= map_wr_i && ent_ok;
      map_err_o <= map_wr_i && !ent_ok;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (prod_wr_i && (prod_i.addr >= IN_BASE) && (prod_i.addr - IN_BASE < 16'(IN_WORDS)))
      in_mem[6'(prod_i.addr - IN_BASE)] <= prod_i.data;
  end

  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  logic [15:0] pre_q;
  wire         tick = (pre_q == 16'(CYC_PER_MS - 1));
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) pre_q <= 16'h0000;
    else         pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
  end

  // ----------------------------------------
  // Copy engine
  // ----------------------------------------
  omb_st_type st_q;
  logic [1:0] c_q;
  logic [1:0] a_q;
  logic [7:0] k_q;
  logic [4:0] w_q;

  omb_area_type cur;
  assign cur = act_q[c_q][a_q];
  wire         do_copy  = (st_q == ST_RUN) && (k_q < cur.count) && (w_q < 5'(OUT_WORDS));
  wire  [15:0] src_idx  = cur.start - IN_BASE + {8'h00, k_q};
  wire  [15:0] src_word = in_mem[src_idx[5:0]];
  wire         cur_st   = stale_q[c_q];
  omb_def_type cur_def;
  assign cur_def = def_q[c_q];
  // RQ7 default data select
  wire  [15:0] def_word = (cur_def == DEF_ONES) ? 16'hFFFF : 16'h0000;
  wire         wr_out   = do_copy && !(cur_st && (cur_def == DEF_HOLD));
  wire  [15:0] out_word = cur_st ? def_word : src_word;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st_q <= ST_LOAD;
      c_q  <= 2'h0;
      a_q  <= 2'h0;
      k_q  <= 8'h00;
      w_q  <= 5'h00;
    end else if (restart_i) begin
      st_q <= ST_LOAD;
    end else begin
      case (st_q)
        ST_LOAD: begin
          st_q <= ST_RUN;
          c_q  <= 2'h0;
          a_q  <= 2'h0;
          k_q  <= 8'h00;
          w_q  <= 5'h00;
        end
        ST_RUN: begin
          // RQ1 areas concatenated in order
          if (do_copy) begin
            k_q <= k_q + 8'h01;
            w_q <= w_q + 5'h01;
          end else begin
            k_q <= 8'h00;
            a_q <= a_q + 2'h1;
            if (a_q == 2'h3) begin
              w_q <= 5'h00;
              c_q <= (c_q == 2'h2) ? 2'h0 : c_q + 2'h1;
            end
          end
        end
        default: st_q <= ST_LOAD;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    // RQ6 substitute default when stale
    if (wr_out)
      out_mem[c_q][w_q[3:0]] <= out_word;
  end

  // ----------------------------------------
  // Per consumer settings and timers
  // ----------------------------------------
  genvar gc, ga;
  generate
    for (gc = 0; gc < NUM_CONS; gc++) begin : g_cons
      logic [NUM_AREAS-1:0] hit;
      for (ga = 0; ga < NUM_AREAS; ga++) begin : g_area
        assign hit[ga] = (prod_i.addr >= act_q[gc][ga].start)
                         && ({1'b0, prod_i.addr} < {1'b0, act_q[gc][ga].start}
                             + {9'h000, act_q[gc][ga].count});
      end
      assign fresh[gc] = prod_wr_i && (|hit);

      always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
          for (int a = 0; a < NUM_AREAS; a++) begin
            pend_q[gc][a] <= '0;
            act_q[gc][a]  <= '0;
          end
          tmo_pend_q[gc] <= TMO_RST;
          tmo_q[gc]      <= TMO_RST;
          def_pend_q[gc] <= DEF_RST;
          def_q[gc]      <= DEF_RST;
          len_q[gc]      <= 5'h00;
        end else begin
          // RQ2 settings kept per consumer
          if (map_wr_i && ent_ok && (map_i.cons == 2'(gc)))
            pend_q[gc][map_i.area] <= map_i.ent;
          // RQ8 eight bit ms timeout
          if (set_wr_i && (set_cons_i == 2'(gc))) begin
            tmo_pend_q[gc] <= set_tmo_i;
            def_pend_q[gc] <= set_def_i;
          end
          // RQ5 apply only on restart
          if (st_q == ST_LOAD) begin
            for (int a = 0; a < NUM_AREAS; a++)
              act_q[gc][a] <= pend_q[gc][a];
            tmo_q[gc] <= tmo_pend_q[gc];
            def_q[gc] <= def_pend_q[gc];
          end
          if (st_q == ST_RUN && !do_copy && a_q == 2'h3 && c_q == 2'(gc))
            len_q[gc] <= w_q;
        end
      end

      always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
          tmr_q[gc]   <= 8'h00;
          stale_q[gc] <= 1'b0;
        end else if ((tmo_q[gc] == 8'h00) || fresh[gc]) begin
          // RQ9 zero disables timeout
          // RQ11 fresh data restarts timer
          tmr_q[gc]   <= 8'h00;
          stale_q[gc] <= 1'b0;
        end else if (tick && !stale_q[gc]) begin
          // RQ10 expiry marks data stale
          if (tmr_q[gc] + 8'h01 >= tmo_q[gc])
            stale_q[gc] <= 1'b1;
          else
            tmr_q[gc] <= tmr_q[gc] + 8'h01;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || (rd_cons_i == 2'h3)) begin
      rd_data_o <= 16'h0000;
      rd_len_o  <= 5'h00;
    end else begin
      rd_data_o <= out_mem[rd_cons_i][rd_idx_i];
      rd_len_o  <= len_q[rd_cons_i];
    end
  end
  assign stale_o   = stale_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_bad_start;
    map_wr_i && (map_i.ent.start < IN_BASE);
  endsequence
  property p_err_start;
    @(posedge mclk_i) disable iff (!nrst_i) s_bad_start |=> map_err_o && !map_ack_o;
  endproperty
  a_err_start: assert property (p_err_start) else $error("Bad start not refused"); // RQ3

  property p_err_count;
    @(posedge mclk_i) disable iff (!nrst_i)
      map_wr_i && (map_i.ent.count > CNT_MAX) |=> map_err_o;
  endproperty
  a_err_count: assert property (p_err_count) else $error("Bad count not refused"); // RQ4

  property p_no_apply;
    @(posedge mclk_i) disable iff (!nrst_i)
      (st_q == ST_RUN) && !restart_i
        |=> $stable(act_q[0][0]) && $stable(tmo_q[0]) && $stable(def_q[1]);
  endproperty
  a_no_apply: assert property (p_no_apply) else $error("Mapping changed without restart"); // RQ5

  property p_zero_off;
    @(posedge mclk_i) disable iff (!nrst_i) (tmo_q[0] == 8'h00) |=> !stale_q[0];
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("Stale with timeout off"); // RQ9

  property p_fresh;
    @(posedge mclk_i) disable iff (!nrst_i) fresh[1] |=> !stale_q[1];
  endproperty
  a_fresh: assert property (p_fresh) else $error("Fresh data left stale"); // RQ11

  property p_expire;
    @(posedge mclk_i) disable iff (!nrst_i) $rose(stale_q[0]) |-> $past(tick) && !$past(fresh[0]);
  endproperty
  a_expire: assert property (p_expire) else $error("Stale without expiry"); // RQ10

  property p_def_ones;
    @(posedge mclk_i) disable iff (!nrst_i)
      do_copy && cur_st && (cur_def == DEF_ONES) |=> out_mem[$past(c_q)][$past(w_q[3:0])] == 16'hFFFF;
  endproperty
  a_def_ones: assert property (p_def_ones) else $error("Default ones not written"); // RQ7

  property p_pass;
    @(posedge mclk_i) disable iff (!nrst_i)
      do_copy && !cur_st && !prod_wr_i |=> out_mem[$past(c_q)][$past(w_q[3:0])] == $past(src_word);
  endproperty
  a_pass: assert property (p_pass) else $error("Mapped word not copied"); // RQ6

endmodule // omb_broker

// File: omb_producer.sv
// Producer model that writes words into the broker input region
`timescale 1ns/100ps
module omb_producer (
  // Clock
  input  wire logic           mclk_i,
  // Producer write port
  output logic                prod_wr_o,
  output omb_pkg::omb_wr_type prod_o
);
  import omb_pkg::*;

  initial begin
    prod_wr_o = 1'b0;
    prod_o    = '0;
  end

  // One word per strobe, bus scrambled when idle
  task automatic put(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    prod_wr_o <= 1'b1;
    prod_o    <= '{addr: a, data: d};
    @(posedge mclk_i);
    prod_wr_o <= 1'b0;
    prod_o    <= '{addr: ~a, data: ~d};
  endtask
endmodule // omb_producer

// File: omb_broker_tb.sv
// Self-checking bench of the output mapping broker
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module omb_broker_tb;
  import omb_pkg::*;
  logic        mclk_i = 0, nrst_i = 0, prod_wr_i, map_wr_i = 0, set_wr_i = 0;
  logic        restart_i = 0, map_ack_o, map_err_o;
  omb_wr_type  prod_i;
  omb_cfg_type map_i = '0;
  omb_def_type set_def_i = DEF_HOLD;
  logic [1:0]  set_cons_i = 0, rd_cons_i = 0;
  logic [7:0]  set_tmo_i = 0;
  logic [3:0]  rd_idx_i = 0;
  logic [15:0] rd_data_o;
  logic [4:0]  rd_len_o;
  logic [2:0]  stale_o;
  int          fails = 0, n_checks = 0;

  always #50 mclk_i = ~mclk_i;

  omb_producer omb_producer_inst (.mclk_i(mclk_i), .prod_wr_o(prod_wr_i), .prod_o(prod_i));
  omb_broker #(.CYC_PER_MS(10)) omb_broker_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .prod_wr_i(prod_wr_i), .prod_i(prod_i), .map_wr_i(map_wr_i), .map_i(map_i),
    .map_ack_o(map_ack_o), .map_err_o(map_err_o), .set_wr_i(set_wr_i),
    .set_cons_i(set_cons_i), .set_tmo_i(set_tmo_i), .set_def_i(set_def_i),
    .restart_i(restart_i), .rd_cons_i(rd_cons_i), .rd_idx_i(rd_idx_i),
    .rd_data_o(rd_data_o), .rd_len_o(rd_len_o), .stale_o(stale_o));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic map(logic [1:0] c, a, logic [15:0] s, logic [7:0] n, logic ok);
    @(posedge mclk_i);
    map_wr_i <= 1'b1;
    map_i    <= '{cons: c, area: a, ent: '{start: s, count: n}};
    @(posedge mclk_i);
    map_wr_i <= 1'b0;
    #1;
    `CHK({map_ack_o, map_err_o}, {ok, ~ok})
  endtask

  task automatic set(logic [1:0] c, logic [7:0] t, omb_def_type d);
    @(posedge mclk_i);
    set_wr_i   <= 1'b1;
    set_cons_i <= c;
    set_tmo_i  <= t;
    set_def_i  <= d;
    @(posedge mclk_i);
    set_wr_i <= 1'b0;
  endtask

  task automatic restart();
    @(posedge mclk_i);
    restart_i <= 1'b1;
    @(posedge mclk_i);
    restart_i <= 1'b0;
  endtask

  task automatic rd(logic [1:0] c, logic [3:0] i);
    @(posedge mclk_i);
    rd_cons_i <= c;
    rd_idx_i  <= i;
    @(posedge mclk_i);
    #1;
  endtask

  task automatic wait_word(logic [1:0] c, logic [3:0] i, logic [15:0] e);
    int k;
    rd(c, i);
    for (k = 0; k < 100 && rd_data_o !== e; k++)
      rd(c, i);
    `CHK(rd_data_o, e)
    if (k == 100)
      report_and_stop();
  endtask

  task automatic stale_in(int c, int lo, int hi);
    int k;
    for (k = 0; k < hi && stale_o[c] !== 1'b1; k++) begin
      @(posedge mclk_i);
      #1;
    end
    `CHK(k >= lo && k < hi, 1'b1)
    if (k == hi)
      report_and_stop();
  endtask

  task automatic fill();
    for (int j = 0; j < 16; j++)
      omb_producer_inst.put(16'(16'h0110 + j), 16'(16'h6000 + j));
    omb_producer_inst.put(16'h0100, 16'h1111);
    omb_producer_inst.put(16'h0101, 16'h2222);
    omb_producer_inst.put(16'h0130, 16'h3333);
    omb_producer_inst.put(16'h013F, 16'h4444);
    omb_producer_inst.put(16'h0108, 16'h5555);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1'b1;
    #1;
    `CHK({map_ack_o, map_err_o, stale_o}, 5'h00)
    map(0, 0, 16'h0100, 8'h02, 1'b1);
    map(0, 1, 16'h0130, 8'h01, 1'b1);
    map(0, 3, 16'h013F, 8'h01, 1'b1);
    map(1, 0, 16'h0108, 8'h01, 1'b1);
    map(2, 0, 16'h0110, 8'h10, 1'b1);
    map(0, 2, 16'h00FF, 8'h01, 1'b0);
    map(0, 2, 16'h0140, 8'h01, 1'b0);
    map(0, 2, 16'h0100, 8'h11, 1'b0);
    map(0, 2, 16'h013F, 8'h02, 1'b0);
    map(3, 0, 16'h0100, 8'h01, 1'b0);
    set(0, 8'h08, DEF_ONES);
    set(1, 8'h06, DEF_HOLD);
    set(2, 8'h00, DEF_ZEROS);
    fill();
    rd(0, 0);
    `CHK(rd_len_o, 5'h00)
    rd(3, 0);
    `CHK({rd_data_o, rd_len_o}, 21'h000000)
    restart();
    fill();
    wait_word(1, 0, 16'h5555);
    `CHK(rd_len_o, 5'h01)
    wait_word(0, 0, 16'h1111);
    rd(0, 1);
    `CHK(rd_data_o, 16'h2222)
    rd(0, 2);
    `CHK(rd_data_o, 16'h3333)
    rd(0, 3);
    `CHK(rd_data_o, 16'h4444)
    `CHK(rd_len_o, 5'h04)
    wait_word(2, 15, 16'h600F);
    `CHK(rd_len_o, 5'h10)
    stale_in(1, 30, 60);
    rd(1, 0);
    `CHK(rd_data_o, 16'h5555)
    wait_word(0, 3, 16'hFFFF);
    omb_producer_inst.put(16'h0100, 16'hABCD);
    #1;
    `CHK(stale_o[0], 1'b0)
    wait_word(0, 0, 16'hABCD);
    omb_producer_inst.put(16'h0101, 16'h2222);
    stale_in(0, 55, 90);
    `CHK(stale_o[2], 1'b0)
    set(2, 8'h01, DEF_ZEROS);
    repeat (30) @(posedge mclk_i);
    #1;
    `CHK(stale_o[2], 1'b0)
    restart();
    stale_in(2, 2, 12);
    wait_word(2, 0, 16'h0000);
    report_and_stop();
  end
endmodule // omb_broker_tb
